// ### core/cmd_pkg.sv
// Shared constants and types for the secure-send and buffer-write command block
package cmd_pkg;
	// -------------------------------------------------------------
	// Command codes and transfer geometry
	// -------------------------------------------------------------
	localparam logic [7:0] CMD_SEC_SEND_DMA = 8'h5f;
	localparam logic [7:0] CMD_BUF_WRITE = 8'he8;
	localparam int PACKET_BYTES = 512;
	localparam int WORD_BITS = 16;
	localparam int WORDS_PER_SECTOR = PACKET_BYTES * 8 / WORD_BITS;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 8;
	// -------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_FEATURE = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_SECTOR = 8'h08;
	localparam logic [7:0] OFF_CYL_LO = 8'h0c;
	localparam logic [7:0] OFF_CYL_HI = 8'h10;
	localparam logic [7:0] OFF_COMMAND = 8'h14;
	localparam logic [7:0] OFF_ERROR = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_DATA = 8'h20;
	localparam logic [7:0] OFF_INT_STATUS = 8'h24;
	localparam logic [7:0] OFF_INT_MASK = 8'h28;
	localparam logic [7:0] OFF_CTRL = 8'h2c;
	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int ERR_ABORT = 2;
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_DREQ = 3;
	localparam int ST_ERR = 0;
	localparam int CTRL_READY = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_W = 2;
	localparam logic [7:0] RST_TASKFILE = 8'h00;
	localparam logic RST_READY = 1'b0;
	// -------------------------------------------------------------
	// Command phases
	// -------------------------------------------------------------
	typedef enum logic [1:0] {PH_IDLE, PH_BUF_DATA, PH_DMA_DATA, PH_FINISH} phase_type;
endpackage : cmd_pkg

// ### core/buf_if.sv
// Link between the command block and its sector buffer
`timescale 1ns/1ps
`default_nettype none
interface buf_if #(parameter int AW = 8, parameter int DW = 16);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : buf_if
`default_nettype wire

// ### core/sector_buffer.sv
// Single-sector word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sector_buffer #(
	parameter int WORDS = 256,
	parameter int AW = 8,
	parameter int DW = 16
) (
	// Clock
	input wire logic mclk,
	// Buffer port
	buf_if.mem bus
);
	import cmd_pkg::*;
	if (WORDS != (1 << AW)) begin : g_chk
		$error("sector_buffer: WORDS must equal 2**AW");
	end
	logic [DW-1:0] mem [WORDS];
	// Read data always come from a register; contents need no reset
	always_ff @(posedge mclk) begin
		if (bus.we) begin
			mem[bus.waddr] <= bus.wdata;
		end
		bus.rdata <= mem[bus.raddr];
	end
endmodule : sector_buffer
`default_nettype wire

// ### core/irq_unit.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module irq_unit #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Events and software access
	input wire logic [W-1:0] event_in,
	input wire logic status_we,
	input wire logic mask_we,
	input wire logic [W-1:0] wdata,
	// State and interrupt
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	import cmd_pkg::*;
	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
	} irq_state_type;
	irq_state_type state_ff, nxt_state;
	always_comb begin
		nxt_state = state_ff;
		// A new event beats a write-one-to-clear in the same cycle
		if (status_we) begin
			nxt_state.status = state_ff.status & ~wdata;
		end
		nxt_state.status = nxt_state.status | event_in;
		if (mask_we) begin
			nxt_state.mask = wdata;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_ff <= irq_state_type'(0);
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign status = state_ff.status;
	assign mask = state_ff.mask;
	assign irq = |(state_ff.status & state_ff.mask);
endmodule : irq_unit
`default_nettype wire

// ### core/cmd_engine.sv
// Command interpreter for secure packet send over DMA and single-sector buffer write
`timescale 1ns/1ps
`default_nettype none
module cmd_engine
	import cmd_pkg::*;
#(
	parameter int WORDS = cmd_pkg::WORDS_PER_SECTOR,
	parameter int AW = $clog2(cmd_pkg::WORDS_PER_SECTOR)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cmd_pkg::ADDR_W-1:0] paddr,
	input wire logic [cmd_pkg::BUS_W-1:0] pwdata,
	output logic [cmd_pkg::BUS_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Slave DMA channel
	output logic dmarq,
	input wire logic dmack,
	input wire logic [cmd_pkg::WORD_BITS-1:0] dma_data,
	// Packet stream to the security engine
	input wire logic sec_ready,
	output logic sec_valid,
	output logic [cmd_pkg::WORD_BITS-1:0] sec_word,
	output logic sec_last,
	output logic [7:0] sec_protocol,
	// Interrupt
	output logic irq
);
	import cmd_pkg::*;
	if (WORDS != (1 << AW) || WORDS * WORD_BITS != PACKET_BYTES * 8) begin : g_chk
		$error("cmd_engine: WORDS must hold exactly one sector and equal 2**AW");
	end
	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		phase_type phase;
		logic acc;
		logic [BUS_W-1:0] prdata;
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] sector;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] command;
		logic [7:0] error;
		logic ready;
		logic data_request;
		logic dmarq;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW-1:0] word;
		logic [7:0] pkts;
		logic sec_valid;
		logic [WORD_BITS-1:0] sec_word;
		logic sec_last;
		logic [IRQ_W-1:0] events;
	} ctl_type;
	ctl_type r_ff, nxt_r;
	logic setup;
	logic go;
	logic wr_go;
	logic rd_go;
	logic idle;
	logic mapped;
	logic dma_take;
	logic [7:0] status_byte;
	logic [BUS_W-1:0] rd_mux;
	logic [IRQ_W-1:0] int_status;
	logic [IRQ_W-1:0] int_mask;
	buf_if #(.AW(AW), .DW(WORD_BITS)) bus ();
	// -------------------------------------------------------------
	// Bus decode
	// -------------------------------------------------------------
	// Every access takes two access cycles: on a read the first latches read data, the second answers
	assign setup = psel && !penable;
	assign go = psel && penable && r_ff.acc;
	assign wr_go = go && pwrite;
	assign rd_go = go && !pwrite;
	assign pready = go;
	assign idle = (r_ff.phase == PH_IDLE);
	assign dma_take = r_ff.dmarq && dmack;
	always_comb begin
		unique case (paddr)
			OFF_FEATURE, OFF_COUNT, OFF_SECTOR, OFF_CYL_LO, OFF_CYL_HI, OFF_COMMAND,
			OFF_ERROR, OFF_STATUS, OFF_DATA, OFF_INT_STATUS, OFF_INT_MASK, OFF_CTRL: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = go && !mapped;
	// Fault, seek, corrected and index bits are held at zero
	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_BUSY] = !idle;
		status_byte[ST_READY] = r_ff.ready;
		status_byte[ST_DREQ] = r_ff.data_request;
		status_byte[ST_ERR] = r_ff.error[ERR_ABORT];
	end
	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			OFF_FEATURE: rd_mux[7:0] = r_ff.feature;
			OFF_COUNT: rd_mux[7:0] = r_ff.count;
			OFF_SECTOR: rd_mux[7:0] = r_ff.sector;
			OFF_CYL_LO: rd_mux[7:0] = r_ff.cyl_lo;
			OFF_CYL_HI: rd_mux[7:0] = r_ff.cyl_hi;
			OFF_COMMAND: rd_mux[7:0] = r_ff.command;
			OFF_ERROR: rd_mux[7:0] = r_ff.error;
			OFF_STATUS: rd_mux[7:0] = status_byte;
			OFF_DATA: rd_mux[WORD_BITS-1:0] = idle ? bus.rdata : '0;
			OFF_INT_STATUS: rd_mux[IRQ_W-1:0] = int_status;
			OFF_INT_MASK: rd_mux[IRQ_W-1:0] = int_mask;
			OFF_CTRL: rd_mux[CTRL_READY] = r_ff.ready;
			default: rd_mux = '0;
		endcase
	end
	// -------------------------------------------------------------
	// Sector buffer link
	// -------------------------------------------------------------
	assign bus.we = wr_go && (paddr == OFF_DATA) && (r_ff.phase == PH_BUF_DATA);
	assign bus.waddr = r_ff.wr_ptr;
	assign bus.wdata = pwdata[WORD_BITS-1:0];
	assign bus.raddr = r_ff.rd_ptr;
	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.sec_valid = 1'b0;
		nxt_r.sec_last = 1'b0;
		nxt_r.events = '0;
		nxt_r.acc = psel && penable && !r_ff.acc;
		if (psel && penable && !r_ff.acc && !pwrite) begin
			nxt_r.prdata = rd_mux;
		end
		if (setup) begin
			nxt_r.prdata = r_ff.prdata;
		end
		// Task-file parameters are frozen while a command runs
		if (wr_go && idle) begin
			unique case (paddr)
				OFF_FEATURE: nxt_r.feature = pwdata[7:0];
				OFF_COUNT: nxt_r.count = pwdata[7:0];
				OFF_SECTOR: nxt_r.sector = pwdata[7:0];
				OFF_CYL_LO: nxt_r.cyl_lo = pwdata[7:0];
				OFF_CYL_HI: nxt_r.cyl_hi = pwdata[7:0];
				OFF_CTRL: nxt_r.ready = pwdata[CTRL_READY];
				OFF_COMMAND: begin
					nxt_r.command = pwdata[7:0];
					nxt_r.error = 8'h00;
					nxt_r.phase = PH_FINISH;
					if (!r_ff.ready) begin
						nxt_r.error[ERR_ABORT] = 1'b1;
					end else if (pwdata[7:0] == CMD_SEC_SEND_DMA && r_ff.count != 8'h00) begin
						nxt_r.phase = PH_DMA_DATA;
						nxt_r.pkts = r_ff.count;
						nxt_r.word = '0;
					end else if (pwdata[7:0] == CMD_BUF_WRITE) begin
						nxt_r.phase = PH_BUF_DATA;
						nxt_r.data_request = 1'b1;
						nxt_r.wr_ptr = '0;
						nxt_r.rd_ptr = '0;
					end else begin
						nxt_r.error[ERR_ABORT] = 1'b1;
					end
				end
				default: nxt_r.feature = r_ff.feature;
			endcase
		end
		// Reads of the data register while idle walk the buffer from word zero
		if (rd_go && idle && paddr == OFF_DATA) begin
			nxt_r.rd_ptr = r_ff.rd_ptr + 1'b1;
		end
		unique case (r_ff.phase)
			PH_IDLE: begin
				// An accepted buffer write raises the request here; clearing it unconditionally would hide it
				nxt_r.data_request = (nxt_r.phase == PH_BUF_DATA);
			end
			PH_BUF_DATA: begin
				if (bus.we) begin
					nxt_r.wr_ptr = r_ff.wr_ptr + 1'b1;
					if (r_ff.wr_ptr == AW'(WORDS - 1)) begin
						nxt_r.data_request = 1'b0;
						nxt_r.phase = PH_FINISH;
						nxt_r.rd_ptr = '0;
					end
				end
			end
			PH_DMA_DATA: begin
				if (dma_take) begin
					nxt_r.sec_valid = 1'b1;
					nxt_r.sec_word = dma_data;
					nxt_r.word = r_ff.word + 1'b1;
					if (r_ff.word == AW'(WORDS - 1)) begin
						nxt_r.sec_last = 1'b1;
						nxt_r.pkts = r_ff.pkts - 8'h01;
						if (r_ff.pkts == 8'h01) begin
							nxt_r.phase = PH_FINISH;
						end
					end
				end
			end
			PH_FINISH: begin
				// Busy drops and the single completion event fire on the same edge
				nxt_r.phase = PH_IDLE;
				nxt_r.events[IRQ_DONE] = 1'b1;
				nxt_r.events[IRQ_ABORT] = r_ff.error[ERR_ABORT];
			end
		endcase
		// The request follows back-pressure one cycle late, so the sink needs one word of slack
		nxt_r.dmarq = (nxt_r.phase == PH_DMA_DATA) && sec_ready;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_ff <= ctl_type'(0);
		end else begin
			r_ff <= nxt_r;
		end
	end
	// -------------------------------------------------------------
	// Submodules
	// -------------------------------------------------------------
	sector_buffer #(.WORDS(WORDS), .AW(AW), .DW(WORD_BITS)) u_buf (
		.mclk(mclk),
		.bus(bus)
	);
	irq_unit #(.W(IRQ_W)) u_irq (
		.mclk(mclk),
		.rst_n(rst_n),
		.event_in(r_ff.events),
		.status_we(wr_go && paddr == OFF_INT_STATUS),
		.mask_we(wr_go && paddr == OFF_INT_MASK),
		.wdata(pwdata[IRQ_W-1:0]),
		.status(int_status),
		.mask(int_mask),
		.irq(irq)
	);
	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign prdata = r_ff.prdata;
	assign dmarq = r_ff.dmarq;
	assign sec_valid = r_ff.sec_valid;
	assign sec_word = r_ff.sec_word;
	assign sec_last = r_ff.sec_last;
	assign sec_protocol = r_ff.feature;
endmodule : cmd_engine
`default_nettype wire

// ### tb/cmd_monitor.sv
// Port-level assertions for the command block
`timescale 1ns/1ps
`default_nettype none
module cmd_monitor
	import cmd_pkg::*;
(
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cmd_pkg::ADDR_W-1:0] paddr,
	input wire logic [cmd_pkg::BUS_W-1:0] prdata,
	input wire logic pready,
	// DMA, stream and interrupt
	input wire logic dmarq,
	input wire logic dmack,
	input wire logic [cmd_pkg::WORD_BITS-1:0] dma_data,
	input wire logic sec_ready,
	input wire logic sec_valid,
	input wire logic [cmd_pkg::WORD_BITS-1:0] sec_word,
	input wire logic sec_last,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_ack_once: assert property (pready |=> !pready)
		else $error("pready held");
	chk_ack_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("pready timing");
	chk_err_bits: assert property (pready && !pwrite && paddr == OFF_ERROR |-> prdata[7:3] == 5'h00 && prdata[1:0] == 2'h0)
		else $error("error bits set");
	chk_status_zero: assert property (pready && !pwrite && paddr == OFF_STATUS |-> prdata[5] == 1'b0 && prdata[2:1] == 2'h0)
		else $error("status bits set");
	chk_req_stall: assert property (!sec_ready |=> !dmarq)
		else $error("request kept");
	chk_word_pass: assert property (dmarq && dmack |=> sec_valid && sec_word == $past(dma_data))
		else $error("word lost");
	chk_no_take: assert property (!(dmarq && dmack) |=> !sec_valid)
		else $error("word invented");
	chk_last_word: assert property (sec_last |-> sec_valid)
		else $error("last alone");
	chk_irq_after: assert property ($rose(irq) |-> !dmarq && $past(dmarq) == 1'b0)
		else $error("irq during transfer");
endmodule : cmd_monitor
bind cmd_engine cmd_monitor u_mon (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.dmarq, .dmack, .dma_data, .sec_ready, .sec_valid, .sec_word, .sec_last, .irq);
`default_nettype wire

// ### tb/dma_host.sv
// Host slave DMA channel model
`timescale 1ns/1ps
`default_nettype none
module dma_host (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bench control
	input wire logic go,
	input wire logic slow,
	// DMA channel
	input wire logic dmarq,
	output logic dmack,
	output logic [15:0] dma_data
);
	logic [15:0] n_ff;
	logic ph_ff;
	// Armed by go before the command is written; slow strobes every other cycle
	assign dmack = go && (!slow || ph_ff);
	// Idle data is inverted so a stale word never looks fresh
	assign dma_data = dmack ? n_ff : ~n_ff;
	always_ff @(posedge mclk) begin
		ph_ff <= rst_n && !ph_ff;
		if (!rst_n) begin
			n_ff <= 16'h0000;
		end else if (dmarq && dmack) begin
			n_ff <= n_ff + 16'h0001;
		end
	end
endmodule : dma_host
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the command block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cmd_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_type;
	logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic sec_ready = 1'b1, go = 1'b0, slow = 1'b1, pready, pslverr, dmarq, dmack;
	logic sec_valid, sec_last, irq, irq_q, err;
	logic [7:0] paddr = 8'h00, sec_protocol;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [15:0] dma_data, sec_word, exp_w = 16'h0000;
	int errors = 0, cmp_count = 0, rises = 0, lasts = 0, tick = 0;
	row_type rows[8] = '{'{OFF_FEATURE, 32'h3c, 32'h3c, 1'b0}, '{OFF_COUNT, 32'h02, 32'h02, 1'b0},
		'{OFF_SECTOR, 32'h5a, 32'h5a, 1'b0}, '{OFF_CYL_LO, 32'ha5, 32'ha5, 1'b0},
		'{OFF_CYL_HI, 32'h0f, 32'h0f, 1'b0}, '{OFF_INT_MASK, 32'h3, 32'h3, 1'b0},
		'{OFF_CTRL, 32'h1, 32'h1, 1'b0}, '{8'h40, 32'hff, 32'h0, 1'b1}};
	always #4 mclk = ~mclk;
	cmd_engine u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.dmarq, .dmack, .dma_data, .sec_ready, .sec_valid, .sec_word, .sec_last, .sec_protocol, .irq);
	dma_host u_host (.mclk, .rst_n, .go, .slow, .dmarq, .dmack, .dma_data);
	task check(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, exp, got);
		end
	endtask : check
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			end_sim();
		end
	endtask : apb
	// Sink stalls one cycle in nine; every streamed word is compared
	always @(posedge mclk) begin
		tick <= tick + 1;
		sec_ready <= (tick % 9) != 0;
		irq_q <= irq;
		if (irq === 1'b1 && irq_q === 1'b0) rises++;
		if (sec_valid === 1'b1) begin
			check("sec_word", sec_word, exp_w);
			check("sec_last", sec_last, exp_w[7:0] == 8'hff);
			exp_w <= exp_w + 16'h0001;
			if (sec_last === 1'b1) lasts++;
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		apb(1'b0, OFF_STATUS, 0);
		check("status", q, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 0);
			check("rdata", q, rows[i].r);
			check("pslverr", err, rows[i].e);
		end
		$display("register test done");
		// Unknown code with done masked off, then zero packets with done masked in
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFF_INT_MASK, i);
			apb(1'b1, OFF_COUNT, 0);
			apb(1'b1, OFF_COMMAND, i ? CMD_SEC_SEND_DMA : 32'h00);
			repeat (4) @(posedge mclk);
			check("irq", irq, i);
			apb(1'b0, OFF_ERROR, 0);
			check("error", q, 32'h04);
			apb(1'b0, OFF_STATUS, 0);
			check("status", q, 32'h41);
			apb(1'b0, OFF_INT_STATUS, 0);
			check("int_status", q, 32'h3);
			apb(1'b1, OFF_INT_STATUS, 32'h3);
			repeat (2) @(posedge mclk);
			check("irq", irq, 0);
		end
		$display("reject test done");
		// Two packets with a strobe every other cycle, then one packet with a strobe every cycle
		for (int k = 0; k < 2; k++) begin
			slow <= (k == 0);
			apb(1'b1, OFF_COUNT, 2 - k);
			go <= 1'b1;
			rises = 0;
			apb(1'b1, OFF_COMMAND, CMD_SEC_SEND_DMA);
			for (int n = 0; irq !== 1'b1; n++) begin
				@(posedge mclk);
				if (n > 4000) begin
					errors++;
					end_sim();
				end
			end
			repeat (20) @(posedge mclk);
			check("words", exp_w, 512 + 256 * k);
			check("packets", lasts, 2 + k);
			check("irq count", rises, 1);
			check("protocol", sec_protocol, 8'h3c);
			apb(1'b0, OFF_STATUS, 0);
			check("status", q, 32'h40);
			apb(1'b1, OFF_INT_STATUS, 32'h3);
			go <= 1'b0;
		end
		$display("dma test done");
		apb(1'b1, OFF_COMMAND, CMD_BUF_WRITE);
		apb(1'b0, OFF_STATUS, 0);
		check("status", q, 32'hc8);
		for (int i = 0; i < WORDS_PER_SECTOR; i++) apb(1'b1, OFF_DATA, 32'hb000 + i);
		repeat (4) @(posedge mclk);
		apb(1'b0, OFF_STATUS, 0);
		check("status", q, 32'h40);
		for (int i = 0; i < WORDS_PER_SECTOR; i++) begin
			apb(1'b0, OFF_DATA, 0);
			check("buffer", q[15:0], 16'hb000 + i);
		end
		$display("buffer test done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
